// ==== hw/hmc_params.svh ====
// Constants for the harvester mode controller
// Summary of operation
// R1 - Cold-start detect moves sleep into wake-up
// R2 - Wake-up keeps regulators off, ready low
// R3 - Ramp both rails, then boost to overcharge
// R4 - Route source to cold-start module until 2.2V
// R5 - Board shorts module output to source if absent
// R6 - Charging storage modulates switch, regulators off
// R7 - Charge-ready in wake-up enters normal, ready high
// R8 - Already charged storage skips charging phase
// R9 - Normal mode regulators follow own enables
// R10 - Enables driven dynamically or tied statically
// R11 - Stay normal between overdischarge and overcharge
// R12 - Above overcharge from normal enters overvoltage
// R13 - Below overdischarge: primary if cell, else shutdown
// R14 - Strap pins are tied statically
// R15 - Primary available when divided voltage exceeds threshold
// R16 - Primary mode warns, returns normal at charge-ready
// R17 - Shutdown warns, returns or sleeps after 600 ms
// R18 - Overvoltage runs boost intermittently, regulators available
// R19 - Synchronised flags; reset enters deep sleep
// R20 - Ready and gating are registered outputs
`ifndef HMC_PARAMS_SVH
`define HMC_PARAMS_SVH
`define HMC_ADDR_STATUS 8'h00
`define HMC_ADDR_TCRIT 8'h04
`define HMC_ADDR_STRAP 8'h08
`define HMC_ADDR_FLAGS 8'h0C
`define HMC_TCRIT_MS 600
`define HMC_CLK_KHZ 100000
`define HMC_TCRIT_CYC (`HMC_TCRIT_MS * `HMC_CLK_KHZ)
`define HMC_SYNC_W 15
`define HMC_FLAG_W 9
`define HMC_STRAP_W 6
`define HMC_MODE_W 8
`define HMC_GATE_W 10
`define HMC_ST_GATE_LSB 8
`define HMC_HTRANS_BIT 1
`define HMC_GATE_RST 10'h020
`endif

// ==== hw/hmc_pkg.sv ====
// Types for the harvester mode controller
package hmc_pkg;
    typedef enum logic [7:0] {
        MD_SLEEP = 8'b0000_0001,
        MD_WRAMP = 8'b0000_0010,
        MD_WBOOST = 8'b0000_0100,
        MD_WCHARGE = 8'b0000_1000,
        MD_NORMAL = 8'b0001_0000,
        MD_OVERV = 8'b0010_0000,
        MD_PRIMARY = 8'b0100_0000,
        MD_SHUTDN = 8'b1000_0000
    } hmc_mode_t;
    typedef struct packed {
        logic [2:0] profile;
        logic [1:0] mpp_ratio_select;
        logic coldstart_source_select;
        logic coldstart_ok;
        logic rails_2v2;
        logic boost_ovch;
        logic storage_node_chrdy;
        logic storage_node_ovch;
        logic storage_node_ovdis;
        logic prim_avail;
        logic low_rail_enable;
        logic high_rail_enable;
    } hmc_in_t;
    typedef struct packed {
        logic ready;
        logic warning;
        logic low_rail_on;
        logic high_rail_on;
        logic coldstart_route;
        logic boost_run;
        logic buck_run;
        logic storage_switch_mod;
        logic storage_switch_on;
        logic prim_switch;
    } hmc_gate_t;
endpackage

// ==== hw/hmc_top.sv ====
// Mode sequencer with AHB-Lite register slave
`timescale 1ns/1ps
`include "hmc_params.svh"
module hmc_top #(
    parameter int unsigned TCRIT_CYCLES = `HMC_TCRIT_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Comparator flags from the analog side
    input wire logic coldstart_ok_i,
    input wire logic rails_2v2_i,
    input wire logic boost_ovch_i,
    input wire logic storage_node_chrdy_i,
    input wire logic storage_node_ovch_i,
    input wire logic storage_node_ovdis_i,
    input wire logic prim_avail_i,
    // Enables from the system controller
    input wire logic low_rail_enable_i,
    input wire logic high_rail_enable_i,
    // Strap pins
    input wire logic [2:0] profile_i,
    input wire logic [1:0] mpp_ratio_select_i,
    input wire logic coldstart_source_select_i,
    // Gating and status outputs
    output logic ready_o,
    output logic warning_o,
    output logic low_rail_enable_o,
    output logic high_rail_enable_o,
    output logic coldstart_route_o,
    output logic boost_run_o,
    output logic buck_run_o,
    output logic storage_switch_mod_o,
    output logic storage_switch_o,
    output logic prim_switch_o,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o
);
    if (TCRIT_CYCLES == 0) begin : g_bad_tcrit
        $error("TCRIT_CYCLES must be at least one");
    end

    // Two-stage synchroniser on every flag, enable and strap input
    logic [`HMC_SYNC_W-1:0] meta_reg, sync_reg;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= {profile_i, mpp_ratio_select_i, coldstart_source_select_i,
                         coldstart_ok_i, rails_2v2_i, boost_ovch_i, storage_node_chrdy_i,
                         storage_node_ovch_i, storage_node_ovdis_i, prim_avail_i,
                         low_rail_enable_i, high_rail_enable_i}; // see R19
            sync_reg <= meta_reg;
        end
    end
    hmc_pkg::hmc_in_t in_s;
    assign in_s = hmc_pkg::hmc_in_t'(sync_reg);

    // Mode sequencer state
    hmc_pkg::hmc_mode_t mode_reg, mode_next;
    hmc_pkg::hmc_gate_t gate_reg, gate_next;
    logic [31:0] crit_cnt_reg, crit_cnt_next;
    logic [31:0] crit_lim_reg;
    logic crit_done;
    assign crit_done = (crit_cnt_reg >= crit_lim_reg - 32'h0000_0001);

    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            hmc_pkg::MD_SLEEP: begin
                if (in_s.coldstart_ok) mode_next = hmc_pkg::MD_WRAMP; // see R1
            end
            hmc_pkg::MD_WRAMP: begin
                if (in_s.rails_2v2) mode_next = hmc_pkg::MD_WBOOST; // see R3
            end
            hmc_pkg::MD_WBOOST: begin
                if (in_s.boost_ovch) begin
                    mode_next = in_s.storage_node_chrdy ? hmc_pkg::MD_NORMAL : hmc_pkg::MD_WCHARGE; // see R8
                end
            end
            hmc_pkg::MD_WCHARGE: begin
                if (in_s.storage_node_chrdy) mode_next = hmc_pkg::MD_NORMAL; // see R7
            end
            hmc_pkg::MD_NORMAL: begin
                // Low storage outranks overcharge if both flags glitch high
                if (in_s.storage_node_ovdis) begin
                    mode_next = in_s.prim_avail ? hmc_pkg::MD_PRIMARY : hmc_pkg::MD_SHUTDN; // see R13, R15
                end else if (in_s.storage_node_ovch) begin
                    mode_next = hmc_pkg::MD_OVERV; // see R12
                end else begin
                    mode_next = hmc_pkg::MD_NORMAL; // see R11
                end
            end
            hmc_pkg::MD_OVERV: begin
                if (!in_s.storage_node_ovch) mode_next = hmc_pkg::MD_NORMAL; // see R18
            end
            hmc_pkg::MD_PRIMARY: begin
                if (in_s.storage_node_chrdy) mode_next = hmc_pkg::MD_NORMAL; // see R16
            end
            hmc_pkg::MD_SHUTDN: begin
                if (in_s.storage_node_chrdy) begin
                    mode_next = hmc_pkg::MD_NORMAL; // see R17
                end else if (crit_done) begin
                    mode_next = hmc_pkg::MD_SLEEP; // see R17
                end
            end
            default: mode_next = hmc_pkg::MD_SLEEP;
        endcase
        crit_cnt_next = (mode_reg == hmc_pkg::MD_SHUTDN && mode_next == hmc_pkg::MD_SHUTDN)
                        ? crit_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
    end

    // Gating follows the next mode so outputs move on the same edge as the mode
    logic nx_ready;
    always_comb begin
        nx_ready = (mode_next == hmc_pkg::MD_NORMAL) || (mode_next == hmc_pkg::MD_OVERV) ||
                   (mode_next == hmc_pkg::MD_PRIMARY) || (mode_next == hmc_pkg::MD_SHUTDN);
        gate_next.ready = nx_ready; // see R2, R7, R20
        gate_next.warning = (mode_next == hmc_pkg::MD_PRIMARY) ||
                            (mode_next == hmc_pkg::MD_SHUTDN); // see R16, R17
        gate_next.low_rail_on = nx_ready && in_s.low_rail_enable; // see R9
        gate_next.high_rail_on = nx_ready && in_s.high_rail_enable; // see R9
        gate_next.coldstart_route = (mode_next == hmc_pkg::MD_SLEEP) ||
                                    (mode_next == hmc_pkg::MD_WRAMP); // see R4
        // Boost idles in overvoltage; re-entry from normal makes it intermittent
        gate_next.boost_run = (mode_next != hmc_pkg::MD_SLEEP) &&
                              (mode_next != hmc_pkg::MD_OVERV); // see R18
        gate_next.buck_run = (mode_next == hmc_pkg::MD_WRAMP) || nx_ready; // see R3
        gate_next.storage_switch_mod = (mode_next == hmc_pkg::MD_WCHARGE); // see R6
        gate_next.storage_switch_on = (mode_next == hmc_pkg::MD_NORMAL) ||
                                      (mode_next == hmc_pkg::MD_OVERV) ||
                                      (mode_next == hmc_pkg::MD_SHUTDN);
        gate_next.prim_switch = (mode_next == hmc_pkg::MD_PRIMARY);
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_reg <= hmc_pkg::MD_SLEEP; // see R19
            // Reset is deep sleep, so the source stays routed to the cold-start input
            gate_reg <= hmc_pkg::hmc_gate_t'(`HMC_GATE_RST); // see R4
            crit_cnt_reg <= 32'h0000_0000;
        end else begin
            mode_reg <= mode_next;
            gate_reg <= gate_next; // see R20
            crit_cnt_reg <= crit_cnt_next;
        end
    end

    assign ready_o = gate_reg.ready;
    assign warning_o = gate_reg.warning;
    assign low_rail_enable_o = gate_reg.low_rail_on;
    assign high_rail_enable_o = gate_reg.high_rail_on;
    assign coldstart_route_o = gate_reg.coldstart_route;
    assign boost_run_o = gate_reg.boost_run;
    assign buck_run_o = gate_reg.buck_run;
    assign storage_switch_mod_o = gate_reg.storage_switch_mod;
    assign storage_switch_o = gate_reg.storage_switch_on;
    assign prim_switch_o = gate_reg.prim_switch;

    // AHB-Lite slave, zero wait states
    logic wr_pend_reg, wr_pend_next;
    logic [7:0] wr_addr_reg, wr_addr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [31:0] crit_lim_next;
    logic accept;
    assign accept = hsel_i && hready_i && htrans_i[`HMC_HTRANS_BIT];

    always_comb begin
        wr_pend_next = accept && hwrite_i;
        wr_addr_next = haddr_i[7:0];
        rdata_next = rdata_reg;
        crit_lim_next = crit_lim_reg;
        if (wr_pend_reg && wr_addr_reg == `HMC_ADDR_TCRIT) begin
            // A zero limit would wrap to the longest wait, so it is held at one
            crit_lim_next = (hwdata_i == 32'h0000_0000) ? 32'h0000_0001 : hwdata_i;
        end
        if (accept && !hwrite_i) begin
            case (haddr_i[7:0])
                `HMC_ADDR_STATUS: begin
                    rdata_next = {14'h0000, gate_reg, mode_reg};
                end
                `HMC_ADDR_TCRIT: rdata_next = crit_lim_reg;
                `HMC_ADDR_STRAP: begin
                    rdata_next = {26'h000_0000, in_s.profile, in_s.mpp_ratio_select,
                                  in_s.coldstart_source_select};
                end
                `HMC_ADDR_FLAGS: rdata_next = {23'h00_0000, sync_reg[`HMC_FLAG_W-1:0]};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rdata_reg <= 32'h0000_0000;
            crit_lim_reg <= TCRIT_CYCLES;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            rdata_reg <= rdata_next;
            crit_lim_reg <= crit_lim_next;
        end
    end

    assign hrdata_o = rdata_reg;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    AST_WAKE_ENTRY: assert property ( // see R1
        mode_reg == hmc_pkg::MD_SLEEP && in_s.coldstart_ok |=> mode_reg == hmc_pkg::MD_WRAMP)
        else $error("cold start did not enter wake-up");
    AST_WAKE_GATED: assert property ( // see R2
        mode_reg inside {hmc_pkg::MD_WRAMP, hmc_pkg::MD_WBOOST, hmc_pkg::MD_WCHARGE}
        |-> !ready_o && !low_rail_enable_o && !high_rail_enable_o)
        else $error("regulators live during wake-up");
    AST_RAMP_DONE: assert property ( // see R3
        mode_reg == hmc_pkg::MD_WRAMP && in_s.rails_2v2 |=> mode_reg == hmc_pkg::MD_WBOOST)
        else $error("ramp did not advance");
    AST_CS_ROUTE: assert property ( // see R4
        coldstart_route_o == (mode_reg inside {hmc_pkg::MD_SLEEP, hmc_pkg::MD_WRAMP}))
        else $error("cold-start routing wrong");
    AST_CHARGE: assert property ( // see R6
        mode_reg == hmc_pkg::MD_WCHARGE |-> storage_switch_mod_o && !ready_o)
        else $error("charging gating wrong");
    AST_CHRDY: assert property ( // see R7
        mode_reg == hmc_pkg::MD_WCHARGE && in_s.storage_node_chrdy |=> mode_reg == hmc_pkg::MD_NORMAL && ready_o)
        else $error("charge-ready not honoured");
    AST_DIRECT: assert property ( // see R8
        mode_reg == hmc_pkg::MD_WBOOST && in_s.boost_ovch && in_s.storage_node_chrdy
        |=> mode_reg == hmc_pkg::MD_NORMAL)
        else $error("charged storage not sent to normal");
    AST_FOLLOW: assert property ( // see R9
        mode_reg == hmc_pkg::MD_NORMAL ##1 mode_reg == hmc_pkg::MD_NORMAL
        |-> low_rail_enable_o == $past(in_s.low_rail_enable) &&
            high_rail_enable_o == $past(in_s.high_rail_enable))
        else $error("regulator does not follow enable");
    AST_STAY: assert property ( // see R11
        mode_reg == hmc_pkg::MD_NORMAL && !in_s.storage_node_ovdis && !in_s.storage_node_ovch
        |=> mode_reg == hmc_pkg::MD_NORMAL)
        else $error("left normal without cause");
    AST_OVERV: assert property ( // see R12
        mode_reg == hmc_pkg::MD_NORMAL && !in_s.storage_node_ovdis && in_s.storage_node_ovch
        |=> mode_reg == hmc_pkg::MD_OVERV ##0 !boost_run_o ##0 ready_o)
        else $error("overvoltage not entered");
    AST_LOW: assert property ( // see R13, R15
        mode_reg == hmc_pkg::MD_NORMAL && in_s.storage_node_ovdis |=> warning_o &&
        mode_reg == ($past(in_s.prim_avail) ? hmc_pkg::MD_PRIMARY : hmc_pkg::MD_SHUTDN))
        else $error("low storage branch wrong");
    AST_PRIM_BACK: assert property ( // see R16
        mode_reg == hmc_pkg::MD_PRIMARY && in_s.storage_node_chrdy |=> mode_reg == hmc_pkg::MD_NORMAL && !warning_o)
        else $error("primary did not return");
    AST_CRIT: assert property ( // see R17
        mode_reg == hmc_pkg::MD_SHUTDN && !in_s.storage_node_chrdy && crit_done
        |=> mode_reg == hmc_pkg::MD_SLEEP && !ready_o && !storage_switch_o)
        else $error("shutdown did not time out");
    AST_EDGE_ONLY: assert property ( // see R20
        $changed(ready_o) |-> $changed(mode_reg))
        else $error("ready moved without mode change");
    AST_RAMP_RUN: assert property ( // see R3
        mode_reg == hmc_pkg::MD_WRAMP |-> boost_run_o && buck_run_o && coldstart_route_o)
        else $error("ramp rails not running");
    AST_BOOST_ONLY: assert property ( // see R3
        mode_reg == hmc_pkg::MD_WBOOST |-> boost_run_o && !buck_run_o && !coldstart_route_o)
        else $error("boost-only phase gating wrong");
    AST_NORMAL_GATE: assert property ( // see R7, R11
        mode_reg == hmc_pkg::MD_NORMAL |-> ready_o && !warning_o && storage_switch_o)
        else $error("normal mode gating wrong");
    AST_OVERV_HOLD: assert property ( // see R18
        mode_reg == hmc_pkg::MD_OVERV |-> ready_o && !boost_run_o && storage_switch_o)
        else $error("overvoltage gating wrong");
    AST_PRIM_HOLD: assert property ( // see R16, R15
        mode_reg == hmc_pkg::MD_PRIMARY |-> ready_o && warning_o && prim_switch_o && !storage_switch_o)
        else $error("primary gating wrong");
    AST_SHUT_HOLD: assert property ( // see R17
        mode_reg == hmc_pkg::MD_SHUTDN |-> ready_o && warning_o && storage_switch_o)
        else $error("shutdown gating wrong");
    AST_CRIT_WAIT: assert property ( // see R17
        mode_reg == hmc_pkg::MD_SHUTDN && !in_s.storage_node_chrdy && !crit_done |=> mode_reg == hmc_pkg::MD_SHUTDN)
        else $error("shutdown left before timeout");
    AST_SLEEP_OFF: assert property ( // see R19
        mode_reg == hmc_pkg::MD_SLEEP
        |-> !ready_o && !low_rail_enable_o && !high_rail_enable_o && !storage_switch_o)
        else $error("regulators live in deep sleep");

    CV_CHARGE_PATH: cover property (
        mode_reg == hmc_pkg::MD_WCHARGE ##1 mode_reg == hmc_pkg::MD_NORMAL);
    CV_PRIMARY: cover property (mode_reg == hmc_pkg::MD_PRIMARY ##1 mode_reg == hmc_pkg::MD_NORMAL);
    CV_SLEEP_AGAIN: cover property (mode_reg == hmc_pkg::MD_SHUTDN ##1 mode_reg == hmc_pkg::MD_SLEEP);
    CV_OVERV: cover property (mode_reg == hmc_pkg::MD_OVERV ##1 mode_reg == hmc_pkg::MD_NORMAL);
    CV_DIRECT: cover property (mode_reg == hmc_pkg::MD_WBOOST ##1 mode_reg == hmc_pkg::MD_NORMAL);
endmodule // hmc_top

// ==== tb/hmc_mcu_model.sv ====
// System controller model that drives the two rail enables
`timescale 1ns/1ps
module hmc_mcu_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Status from the controller and wishes from the bench
    input wire logic ready_i,
    input wire logic early_i,
    input wire logic want_low_i,
    input wire logic want_high_i,
    // Enables toward the controller
    output logic low_rail_enable_o,
    output logic high_rail_enable_o
);
    logic low_reg;
    logic high_reg;
    logic low_next;
    logic high_next;
    // Early mode breaks the ready handshake on purpose
    always_comb begin
        low_next = 1'b0;
        high_next = 1'b0;
        if (ready_i || early_i) begin
            low_next = want_low_i;
            high_next = want_high_i;
        end
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            low_reg <= 1'b0;
            high_reg <= 1'b0;
        end else begin
            low_reg <= low_next;
            high_reg <= high_next;
        end
    end
    assign low_rail_enable_o = low_reg;
    assign high_rail_enable_o = high_reg;
endmodule // hmc_mcu_model

// ==== tb/harvester_mode_controller_tb.sv ====
// Self-checking bench for the harvester mode controller
`timescale 1ns/1ps
module harvester_mode_controller_tb;
    localparam int unsigned TCRIT = 20;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    // Flag order: cold, rails, boost_ovch, chrdy, ovch, ovdis, prim
    logic [6:0] flg = 7'h00;
    logic want_low = 1'b0;
    logic want_high = 1'b0;
    logic early = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hready, low_en, high_en, ready, warn, lo_o, hi_o, route, sw_mod, prim_sw;
    logic hresp, boost, buck, sw_on;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    hmc_mcu_model mcu (.clk_i(clk_i), .rstn_i(rstn_i), .ready_i(ready), .early_i(early), .want_low_i(want_low),
        .want_high_i(want_high), .low_rail_enable_o(low_en), .high_rail_enable_o(high_en));
    hmc_top #(.TCRIT_CYCLES(TCRIT)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .coldstart_ok_i(flg[6]),
        .rails_2v2_i(flg[5]), .boost_ovch_i(flg[4]), .storage_node_chrdy_i(flg[3]), .storage_node_ovch_i(flg[2]),
        .storage_node_ovdis_i(flg[1]), .prim_avail_i(flg[0]), .low_rail_enable_i(low_en), .high_rail_enable_i(high_en),
        .profile_i(3'h5), .mpp_ratio_select_i(2'h2), .coldstart_source_select_i(1'b1), .ready_o(ready),
        .warning_o(warn), .low_rail_enable_o(lo_o), .high_rail_enable_o(hi_o), .coldstart_route_o(route),
        .boost_run_o(boost), .buck_run_o(buck), .storage_switch_mod_o(sw_mod), .storage_switch_o(sw_on),
        .prim_switch_o(prim_sw), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp));
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic cmp_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cmp_bit(input string name, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask
    // One single AHB-Lite transfer; waits on hready in both phases
    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] data);
        @(posedge clk_i);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= addr;
        do @(posedge clk_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_i); while (hready !== 1'b1);
        data = hrdata;
    endtask
    task automatic setf(input logic [6:0] f);
        @(posedge clk_i);
        flg <= f;
        repeat (5) @(posedge clk_i);
    endtask
    task automatic chk(input logic [7:0] m, input logic r, input logic w);
        ahb(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
        // Let outputs settle past the launching edge
        #1;
        cmp_word("mode", {24'h00_0000, m}, {24'h00_0000, rd[7:0]});
        cmp_bit("ready", r, ready);
        cmp_bit("warning", w, warn);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(hmc_pkg::MD_SLEEP, 1'b0, 1'b0);
        cmp_bit("route", 1'b1, route);
        cmp_bit("hresp", 1'b0, hresp);
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
        cmp_word("tcrit", TCRIT, rd);
        ahb(1'b1, 32'h0000_0004, 32'h0000_001E, rd);
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
        cmp_word("tcrit", 32'h0000_001E, rd);
        ahb(1'b0, 32'h0000_0008, 32'h0000_0000, rd);
        cmp_word("strap", 32'h0000_002D, rd);
        ahb(1'b0, 32'h0000_0010, 32'h0000_0000, rd);
        cmp_word("unmapped", 32'h0000_0000, rd);
        early <= 1'b1;
        want_low <= 1'b1;
        want_high <= 1'b1;
        setf(7'b100_0000);
        chk(hmc_pkg::MD_WRAMP, 1'b0, 1'b0);
        cmp_bit("boost", 1'b1, boost);
        cmp_bit("buck", 1'b1, buck);
        cmp_bit("route", 1'b1, route);
        cmp_bit("low", 1'b0, lo_o);
        cmp_bit("high", 1'b0, hi_o);
        setf(7'b110_0000);
        chk(hmc_pkg::MD_WBOOST, 1'b0, 1'b0);
        cmp_bit("route", 1'b0, route);
        cmp_bit("boost", 1'b1, boost);
        cmp_bit("buck", 1'b0, buck);
        setf(7'b111_0000);
        chk(hmc_pkg::MD_WCHARGE, 1'b0, 1'b0);
        cmp_bit("switch_mod", 1'b1, sw_mod);
        cmp_bit("low", 1'b0, lo_o);
        early <= 1'b0;
        setf(7'b111_1000);
        chk(hmc_pkg::MD_NORMAL, 1'b1, 1'b0);
        for (int v = 0; v < 4; v++) begin
            @(posedge clk_i);
            want_low <= v[1];
            want_high <= v[0];
            repeat (6) @(posedge clk_i);
            #1;
            cmp_bit("low", v[1], lo_o);
            cmp_bit("high", v[0], hi_o);
        end
        setf(7'b111_1100);
        chk(hmc_pkg::MD_OVERV, 1'b1, 1'b0);
        cmp_bit("low", 1'b1, lo_o);
        cmp_bit("boost", 1'b0, boost);
        setf(7'b111_1000);
        chk(hmc_pkg::MD_NORMAL, 1'b1, 1'b0);
        cmp_bit("switch", 1'b1, sw_on);
        setf(7'b111_0011);
        chk(hmc_pkg::MD_PRIMARY, 1'b1, 1'b1);
        cmp_bit("prim_switch", 1'b1, prim_sw);
        setf(7'b111_1000);
        chk(hmc_pkg::MD_NORMAL, 1'b1, 1'b0);
        setf(7'b111_0010);
        chk(hmc_pkg::MD_SHUTDN, 1'b1, 1'b1);
        cmp_bit("high", 1'b1, hi_o);
        setf(7'b111_1000);
        chk(hmc_pkg::MD_NORMAL, 1'b1, 1'b0);
        setf(7'b000_0010);
        chk(hmc_pkg::MD_SHUTDN, 1'b1, 1'b1);
        repeat (40) @(posedge clk_i);
        chk(hmc_pkg::MD_SLEEP, 1'b0, 1'b0);
        cmp_bit("low", 1'b0, lo_o);
        cmp_bit("switch", 1'b0, sw_on);
        rstn_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        setf(7'b100_0000);
        setf(7'b110_1000);
        setf(7'b111_1000);
        chk(hmc_pkg::MD_NORMAL, 1'b1, 1'b0);
        stop_test();
    end
endmodule // harvester_mode_controller_tb
